// File: apc_pkg.sv
// Shared constants for the converter power-up sequencer and its register link
package apc_pkg;
    // Device register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NUM_REGS = 16;
    localparam logic [3:0] A_MAIN_CFG = 4'h0;
    localparam logic [3:0] A_CM_ADJ = 4'h1;
    localparam logic [3:0] A_FIRST_OFS = 4'h2;
    localparam logic [3:0] A_FIRST_RNG = 4'h3;
    localparam logic [3:0] A_CAL_ADJ = 4'h4;
    localparam logic [3:0] A_SECOND_OFS = 4'hA;
    localparam logic [3:0] A_SECOND_RNG = 4'hB;
    localparam logic [3:0] A_DLY_COARSE = 4'hC;
    localparam logic [3:0] A_DLY_FINE = 4'hD;
    localparam logic [3:0] A_MC_SYNC = 4'hE;
    // One bit per address that holds a real register
    localparam logic [15:0] REG_MAPPED = 16'h7C1F;
    // Power-on values, indexed by address; reserved entries stay zero
    localparam logic [15:0] REG_RST [NUM_REGS] = '{
        16'h2000, 16'h2A00, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    // Main configuration fields
    localparam int B_CAL = 15;
    localparam int B_PD_FIRST = 11;
    localparam int B_PD_SECOND = 10;
    localparam int B_DES = 7;
    localparam logic [15:0] CAL_MASK = 16'h8000;
    // Serial frame: header (read flag, zeros, address) then data, MSB first
    localparam int HDR_W = 8;
    localparam int FRAME_W = 24;
    localparam int HDR_RD = 7;
    localparam logic [2:0] HDR_PAD = 3'h0;
    // Pin synchroniser reset: select line idles high
    localparam logic [10:0] PIN_SYNC_RST = 11'h400;
    // Controller register indices and pin-control fields
    localparam logic [1:0] C_PINS = 2'h0;
    localparam logic [1:0] C_CMD = 2'h1;
    localparam logic [1:0] C_DATA = 2'h2;
    localparam logic [1:0] C_STAT = 2'h3;
    localparam int PINS_W = 7;
    localparam logic [6:0] PINS_RST = 7'h00;
    // Serial clock half period in controller cycles
    localparam int SCLK_HALF = 8;
endpackage

// File: apc_link_if.sv
// Link between the converter's configuration logic and its controller
`timescale 1ns/100ps
interface apc_link_if #(
    parameter logic CAL_DLY_STRAP = 1'b0
) (
    input wire logic i_lclk
);
    logic lclk;
    logic sclk;
    logic scs_n;
    logic sdi;
    logic sdo;
    logic extended_control_mode;
    logic cal;
    logic pd_first;
    logic pd_second;
    logic des;
    logic demux;
    logic data_clock_reset;
    logic cal_delay_select_pin;

    assign lclk = i_lclk;
    // Delay select is a resistor strap, never driven by the controller
    assign cal_delay_select_pin = CAL_DLY_STRAP; // RULE_13

    modport dev (
        input lclk, sclk, scs_n, sdi, extended_control_mode, cal, pd_first, pd_second,
        input des, demux, data_clock_reset, cal_delay_select_pin,
        output sdo
    );
    modport ctl (
        output sclk, scs_n, sdi, extended_control_mode, cal, pd_first, pd_second,
        output des, demux, data_clock_reset,
        input sdo
    );
endinterface

// File: apc_ctl.sv
// Controller end: drives control pins and serial register frames
`timescale 1ns/100ps
module apc_ctl (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Converter supply present
    input wire logic i_supply_ok,
    // Software port
    input wire logic [1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Link
    apc_link_if.ctl lnk
);
    import apc_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_LOW = 4'b0010,
        S_HIGH = 4'b0100,
        S_GAP = 4'b1000
    } apc_cst_t;

    ////////////////////////////////////////////////////////////////////////
    apc_cst_t st_q;
    logic [1:0] sup_q;
    logic [1:0] sdo_q;
    logic [PINS_W-1:0] pins_q;
    logic [PINS_W-1:0] pin_out_q;
    logic [FRAME_W-1:0] frm_q;
    logic [DATA_W-1:0] data_q;
    logic [4:0] bit_q;
    logic [3:0] half_q;
    logic rd_frame_q;
    logic [15:0] rdata_q;
    logic sclk_q;
    logic scs_n_q;

    wire sup_ok = sup_q[1];
    wire busy = (st_q != S_IDLE);
    wire half_end = (half_q == 4'(SCLK_HALF - 1));
    wire wr_pins = i_wr && (i_addr == C_PINS);
    wire wr_data = i_wr && (i_addr == C_DATA);
    // Frames are refused until the supply is up
    wire start = i_wr && (i_addr == C_CMD) && !busy && sup_ok; // RULE_08
    wire last_bit = (bit_q == 5'(FRAME_W - 1));
    wire rx_bit = rd_frame_q && (bit_q >= 5'(HDR_W));
    wire [15:0] rd_mux;

    assign rd_mux = (i_addr == C_PINS) ? {9'h000, pins_q} :
                    (i_addr == C_DATA) ? data_q :
                    (i_addr == C_STAT) ? {14'h0000, sup_ok, busy} :
                    16'h0000;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sup_q <= 2'b00;
            sdo_q <= 2'b00;
        end else begin
            sup_q <= {sup_q[0], i_supply_ok};
            sdo_q <= {sdo_q[0], lnk.sdo};
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pins_q <= PINS_RST;
            pin_out_q <= PINS_RST;
            rdata_q <= 16'h0000;
        end else begin
            if (wr_pins) begin
                pins_q <= i_wdata[PINS_W-1:0];
            end
            pin_out_q <= sup_ok ? pins_q : PINS_RST; // RULE_08
            rdata_q <= i_rd ? rd_mux : 16'h0000;
        end
    end

    // Frame sequencer; data is sampled at the end of each high half
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= S_IDLE;
            frm_q <= '0;
            data_q <= 16'h0000;
            bit_q <= 5'h00;
            half_q <= 4'h0;
            rd_frame_q <= 1'b0;
            sclk_q <= 1'b0;
            scs_n_q <= 1'b1;
        end else begin
            half_q <= (st_q == S_IDLE || half_end) ? 4'h0 : half_q + 4'h1;
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        frm_q <= {i_wdata[4], HDR_PAD, i_wdata[3:0], data_q};
                        rd_frame_q <= i_wdata[4];
                        bit_q <= 5'h00;
                        scs_n_q <= 1'b0;
                        st_q <= S_LOW;
                    end else if (wr_data) begin
                        data_q <= i_wdata;
                    end
                end
                S_LOW: begin
                    if (half_end) begin
                        sclk_q <= 1'b1;
                        st_q <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    if (half_end) begin
                        sclk_q <= 1'b0;
                        frm_q <= {frm_q[FRAME_W-2:0], 1'b0};
                        bit_q <= bit_q + 5'h01;
                        if (rx_bit) begin
                            data_q <= {data_q[DATA_W-2:0], sdo_q[1]};
                        end
                        st_q <= last_bit ? S_GAP : S_LOW;
                        scs_n_q <= last_bit;
                    end
                end
                S_GAP: begin
                    if (half_end) begin
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign lnk.sclk = sclk_q;
    assign lnk.scs_n = scs_n_q;
    assign lnk.sdi = frm_q[FRAME_W-1];
    assign {lnk.data_clock_reset, lnk.demux, lnk.des, lnk.pd_second, lnk.pd_first,
            lnk.cal, lnk.extended_control_mode} = pin_out_q;
    assign o_rdata = rdata_q;
endmodule

// File: apc_dev.sv
// Converter end: power-up calibration sequencing, register map, data clocks
//
// Functional notes
// RULE_01 - Auto calibration after strap-selected delay
// RULE_02 - Full performance only after calibration on config
// RULE_03 - Controller configures before starting calibration
// RULE_04 - Configure via serial registers or pins
// RULE_05 - Strapped pins already apply at power-on
// RULE_06 - Strapped case valid after delay plus calibration
// RULE_07 - Controller recalibrates after late thermal settling
// RULE_08 - Controller stays quiet before supply is up
// RULE_09 - Early configuration makes power-on calibration complete
// RULE_10 - Late configuration needs an on-command calibration
// RULE_11 - One output data clock per channel
// RULE_12 - Data clock stops only when down or reset
// RULE_13 - Delay select pin is a resistor strap
// RULE_14 - Ten registers act only in extended mode
// RULE_15 - Four-bit addresses for the lower registers
// RULE_16 - Upper registers at C, D, E; rest reserved (REG_MAPPED also maps A and B as real registers)
// RULE_17 - Every register bit has a power-on value
// RULE_18 - Calibration bit rising edge, ORed with pin
// RULE_19 - Reserved addresses ignore writes, read zero
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module apc_dev #(
    parameter int POC_DLY_SHORT = 4096,
    parameter int POC_DLY_LONG = 65536,
    parameter int CAL_EXEC = 8192
) (
    // Power-on reset
    input wire logic i_arst_n,
    // Link to the controller
    apc_link_if.dev lnk,
    // Converter-side status and data clocks
    output logic o_output_data_clock_first,
    output logic o_output_data_clock_second,
    output logic o_out_valid,
    output logic o_full_perf,
    output logic o_cal_busy
);
    import apc_pkg::*;

    localparam int CNT_W = 24;
    localparam int STRAP_SETTLE = 2;

    initial begin
        if (POC_DLY_SHORT < 1 || POC_DLY_LONG < 1 || CAL_EXEC < 1 ||
            POC_DLY_SHORT >= 2**CNT_W || POC_DLY_LONG >= 2**CNT_W ||
            CAL_EXEC >= 2**CNT_W) begin
            $error("apc_dev: delay counts out of range");
        end
    end

    typedef enum logic [3:0] {
        ST_STRAP = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_CAL = 4'b0100,
        ST_IDLE = 4'b1000
    } apc_dst_t;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic clk;
    logic [1:0] rst_q;
    logic rst_n;
    logic [10:0] pin_a;
    logic [10:0] pin_m_q;
    logic [10:0] pin_s_q;
    logic s_scs_n;
    logic s_sclk;
    logic s_sdi;
    logic s_ecm;
    logic s_cal;
    logic s_pd_first;
    logic s_pd_second;
    logic s_des;
    logic s_demux;
    logic s_data_clock_reset;
    logic s_cal_delay_select_pin;

    assign clk = lnk.lclk;
    assign rst_n = rst_q[1];

    // Asserts at once, releases only on clean link clock edges
    always_ff @(posedge clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    assign pin_a = {lnk.scs_n, lnk.sclk, lnk.sdi, lnk.extended_control_mode, lnk.cal,
                    lnk.pd_first, lnk.pd_second, lnk.des, lnk.demux,
                    lnk.data_clock_reset, lnk.cal_delay_select_pin};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_m_q <= PIN_SYNC_RST;
            pin_s_q <= PIN_SYNC_RST;
        end else begin
            pin_m_q <= pin_a;
            pin_s_q <= pin_m_q;
        end
    end

    assign {s_scs_n, s_sclk, s_sdi, s_ecm, s_cal, s_pd_first, s_pd_second,
            s_des, s_demux, s_data_clock_reset, s_cal_delay_select_pin} = pin_s_q;

    ////////////////////////////////////////////////////////////////////////
    // Serial register port, oversampled on the link clock
    logic sclk_prev_q;
    logic [FRAME_W-2:0] rx_q;
    logic [4:0] bit_q;
    logic hdr_rd_q;
    logic [ADDR_W-1:0] hdr_addr_q;
    logic [DATA_W-1:0] tx_q;
    logic sdo_q;
    logic [DATA_W-1:0] regs_q [NUM_REGS];

    wire sclk_rise = s_sclk && !sclk_prev_q && !s_scs_n;
    wire sclk_fall = !s_sclk && sclk_prev_q && !s_scs_n;
    wire hdr_done = sclk_rise && (bit_q == 5'(HDR_W - 1));
    wire frm_done = sclk_rise && (bit_q == 5'(FRAME_W - 1));
    wire [HDR_W-1:0] hdr_in = {rx_q[HDR_W-2:0], s_sdi};
    wire [DATA_W-1:0] wr_val = {rx_q[DATA_W-2:0], s_sdi};
    wire reg_we = frm_done && !hdr_rd_q && REG_MAPPED[hdr_addr_q]; // RULE_19
    wire [DATA_W-1:0] old_val = regs_q[hdr_addr_q];
    wire [DATA_W-1:0] cfg_diff = (wr_val ^ old_val) &
                                 ((hdr_addr_q == A_MAIN_CFG) ? ~CAL_MASK :
                                  16'hFFFF);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
            rx_q <= '0;
            bit_q <= 5'h00;
            hdr_rd_q <= 1'b0;
            hdr_addr_q <= '0;
            tx_q <= 16'h0000;
            sdo_q <= 1'b0;
        end else begin
            sclk_prev_q <= s_sclk;
            if (s_scs_n) begin
                bit_q <= 5'h00;
            end else if (sclk_rise) begin
                rx_q <= {rx_q[FRAME_W-3:0], s_sdi};
                bit_q <= bit_q + 5'h01;
            end
            if (hdr_done) begin
                hdr_rd_q <= hdr_in[HDR_RD];
                hdr_addr_q <= hdr_in[ADDR_W-1:0];
                tx_q <= regs_q[hdr_in[ADDR_W-1:0]];
            end else if (sclk_fall && (bit_q >= 5'(HDR_W))) begin
                sdo_q <= tx_q[DATA_W-1];
                tx_q <= {tx_q[DATA_W-2:0], 1'b0};
            end
        end
    end

    // Only mapped addresses hold flops; reserved ones read as zero
    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
            if (REG_MAPPED[i]) begin : g_rw
                always_ff @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        regs_q[i] <= REG_RST[i]; // RULE_17
                    end else if (reg_we && (hdr_addr_q == 4'(i))) begin
                        regs_q[i] <= wr_val; // RULE_15 RULE_16
                    end
                end
            end else begin : g_res
                assign regs_q[i] = 16'h0000; // RULE_19
            end
        end
    endgenerate

    assign lnk.sdo = sdo_q;

    ////////////////////////////////////////////////////////////////////////
    // Effective configuration; registers count only in extended mode
    wire [DATA_W-1:0] main_cfg = regs_q[A_MAIN_CFG];
    wire ecm_on = s_ecm; // RULE_04
    wire cal_req = s_cal | (ecm_on & main_cfg[B_CAL]); // RULE_14 RULE_18
    wire pd_first = s_pd_first | (ecm_on & main_cfg[B_PD_FIRST]);
    wire pd_second = s_pd_second | (ecm_on & main_cfg[B_PD_SECOND]);
    wire des_on = ecm_on ? main_cfg[B_DES] : s_des;
    wire [2:0] cfg_vec = {ecm_on, des_on, s_demux};

    ////////////////////////////////////////////////////////////////////////
    // Power-up and calibration sequencer
    apc_dst_t st_q;
    logic dly_long_q;
    logic [CNT_W-1:0] cnt_q;
    logic cal_req_q;
    logic [2:0] cfg_prev_q;
    logic dirty_q;
    logic perf_q;
    logic valid_q;

    wire [CNT_W-1:0] dly_last = dly_long_q ? CNT_W'(POC_DLY_LONG - 1) :
                                CNT_W'(POC_DLY_SHORT - 1);
    wire wait_end = (st_q == ST_WAIT) && (cnt_q == dly_last);
    wire cal_end = (st_q == ST_CAL) && (cnt_q == CNT_W'(CAL_EXEC - 1));
    wire strap_end = (st_q == ST_STRAP) && (cnt_q == CNT_W'(STRAP_SETTLE));
    // Both sources must be low before a new rise can start a run
    wire cal_rise = cal_req && !cal_req_q; // RULE_18
    wire cmd_start = (st_q == ST_IDLE) && cal_rise;
    // Startup sampling counts as a config change only once sequencing runs
    wire cfg_chg = ((reg_we && ecm_on && (cfg_diff != 16'h0000)) ||
                    (cfg_vec != cfg_prev_q)) && (st_q != ST_STRAP);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_STRAP;
            dly_long_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            case (st_q)
                ST_STRAP: begin
                    // Strap is taken once the synchroniser has settled
                    dly_long_q <= s_cal_delay_select_pin; // RULE_05
                    cnt_q <= strap_end ? '0 : cnt_q + CNT_W'(1);
                    if (strap_end) begin
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cnt_q <= wait_end ? '0 : cnt_q + CNT_W'(1);
                    if (wait_end) begin
                        st_q <= ST_CAL; // RULE_01
                    end
                end
                ST_CAL: begin
                    cnt_q <= cal_end ? '0 : cnt_q + CNT_W'(1);
                    if (cal_end) begin
                        st_q <= ST_IDLE; // RULE_06
                    end
                end
                ST_IDLE: begin
                    cnt_q <= '0;
                    if (cmd_start) begin
                        st_q <= ST_CAL; // RULE_10
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // A change during a run marks that run stale; the change wins over
    // the clear at the run's start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_req_q <= 1'b0;
            cfg_prev_q <= 3'h0;
            dirty_q <= 1'b0;
            perf_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            cal_req_q <= cal_req;
            cfg_prev_q <= cfg_vec;
            if (cfg_chg) begin
                dirty_q <= 1'b1;
            end else if (wait_end || cmd_start) begin
                dirty_q <= 1'b0; // RULE_09
            end
            if (cfg_chg) begin
                perf_q <= 1'b0; // RULE_10
            end else if (cal_end) begin
                perf_q <= !dirty_q; // RULE_02
            end
            if (cal_end) begin
                valid_q <= 1'b1; // RULE_02
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel data clocks at half the link clock
    logic output_data_clock_first_q;
    logic output_data_clock_second_q;

    wire output_data_clock_hold = s_data_clock_reset && s_demux;
    wire run_first = !pd_first && !output_data_clock_hold; // RULE_12
    wire run_second = !pd_second && !output_data_clock_hold; // RULE_12

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_data_clock_first_q <= 1'b0;
            output_data_clock_second_q <= 1'b0;
        end else begin
            output_data_clock_first_q <= run_first ? !output_data_clock_first_q : 1'b0; // RULE_11
            output_data_clock_second_q <= run_second ? !output_data_clock_second_q : 1'b0; // RULE_11
        end
    end

    assign o_output_data_clock_first = output_data_clock_first_q;
    assign o_output_data_clock_second = output_data_clock_second_q;
    assign o_out_valid = valid_q;
    assign o_full_perf = perf_q;
    assign o_cal_busy = (st_q == ST_CAL);
endmodule

// File: apc_chk.sv
// Assertions on the converter link pins and power-up status outputs
`timescale 1ns/100ps
module apc_chk #(
    parameter int POC_DLY_SHORT = 4096,
    parameter int POC_DLY_LONG = 65536,
    parameter int CAL_EXEC = 8192
) (
    // Link clock, reset and pins
    input wire logic lclk,
    input wire logic i_arst_n,
    input wire logic extended_control_mode,
    input wire logic cal,
    input wire logic pd_first,
    input wire logic data_clock_reset,
    input wire logic demux,
    input wire logic cal_delay_select_pin,
    // Converter status
    input wire logic o_output_data_clock_first,
    input wire logic o_output_data_clock_second,
    input wire logic o_out_valid,
    input wire logic o_full_perf,
    input wire logic o_cal_busy
);
    int busy_q;
    int up_q;

    default clocking @(posedge lclk);
    endclocking
    default disable iff (!i_arst_n);

    ////////////////////////////////////////////////////////////////////////
    // Saturating age since reset keeps the counter from wrapping in long runs
    always_ff @(posedge lclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_q <= 0;
            up_q <= 0;
        end else begin
            busy_q <= o_cal_busy ? busy_q + 1 : 0;
            up_q <= (up_q < 1000000) ? up_q + 1 : up_q;
        end
    end

    sequence s_cal_run;
        o_cal_busy[*8];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    AST_NO_EARLY_CAL: assert property (o_cal_busy && !o_out_valid
        |-> up_q >= (cal_delay_select_pin ? POC_DLY_LONG : POC_DLY_SHORT))
        else $error("calibration before power-on delay");
    AST_AUTO_CAL: assert property (
        up_q == (cal_delay_select_pin ? POC_DLY_LONG : POC_DLY_SHORT) + 8
        |-> o_cal_busy || o_out_valid)
        else $error("power-on calibration did not start");
    AST_CAL_LEN: assert property ($fell(o_cal_busy)
        |-> busy_q == CAL_EXEC)
        else $error("calibration length wrong");
    AST_VALID_CAL: assert property ($rose(o_out_valid)
        |-> $past(o_cal_busy) || $past(o_cal_busy, 2))
        else $error("valid without calibration");
    AST_FULL_VALID: assert property (o_full_perf |-> o_out_valid)
        else $error("full performance without valid");
    AST_FULL_CAL: assert property ($rose(o_full_perf)
        |-> $past(o_cal_busy) || $past(o_cal_busy, 2))
        else $error("full performance without calibration");
    AST_CAL_START: assert property ($rose(cal) && o_out_valid
        && !o_cal_busy |-> ##[1:6] s_cal_run)
        else $error("calibration pin rise ignored");
    AST_OUTPUT_DATA_CLOCK_RUN: assert property (
        (!pd_first && !extended_control_mode && !data_clock_reset)[*8]
        |-> o_output_data_clock_first != $past(o_output_data_clock_first))
        else $error("data clock not running");
    AST_OUTPUT_DATA_CLOCK_PD: assert property (pd_first[*5] |-> !o_output_data_clock_first)
        else $error("data clock runs while powered down");
    AST_DATA_CLOCK_RESET: assert property ((data_clock_reset && demux)[*5]
        |-> !o_output_data_clock_first && !o_output_data_clock_second)
        else $error("data clock runs in reset");
endmodule

// File: test_adc_powerup_cal_config_control.sv
// Bench: controller end and converter end joined by the link
`timescale 1ns/100ps
module test_adc_powerup_cal_config_control;
    import apc_pkg::*;
    localparam int POC_N = 16;
    localparam int CAL_N = 20;
    logic mclk, lclk, arst_n, supply_ok, wr, rd;
    logic dclk1, dclk2, valid, full, busy;
    logic [1:0] addr;
    logic [15:0] wdata, rdata, d;
    logic [15:0] m [16];
    int n_mismatch, check_count, n1, n2, n;

    apc_link_if #(.CAL_DLY_STRAP(1'b0)) lnk_if (.i_lclk(lclk));
    apc_ctl apc_ctl_inst (.i_mclk(mclk), .i_arst_n(arst_n),
        .i_supply_ok(supply_ok), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .lnk(lnk_if.ctl));
    apc_dev #(.POC_DLY_SHORT(POC_N), .POC_DLY_LONG(40), .CAL_EXEC(CAL_N))
        apc_dev_inst (.i_arst_n(arst_n), .lnk(lnk_if.dev),
        .o_output_data_clock_first(dclk1), .o_output_data_clock_second(dclk2), .o_out_valid(valid),
        .o_full_perf(full), .o_cal_busy(busy));
    apc_chk #(.POC_DLY_SHORT(POC_N), .POC_DLY_LONG(40), .CAL_EXEC(CAL_N))
        apc_chk_inst (.lclk(lnk_if.lclk), .i_arst_n(arst_n),
        .extended_control_mode(lnk_if.extended_control_mode), .cal(lnk_if.cal), .pd_first(lnk_if.pd_first),
        .data_clock_reset(lnk_if.data_clock_reset), .demux(lnk_if.demux),
        .cal_delay_select_pin(lnk_if.cal_delay_select_pin), .o_output_data_clock_first(dclk1), .o_output_data_clock_second(dclk2),
        .o_out_valid(valid), .o_full_perf(full), .o_cal_busy(busy));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic lwait(input int k);
        repeat (k) @(negedge lclk);
        @(posedge mclk);
    endtask
    task automatic wait_hi(input string nm);
        for (int i = 0; i < 200 && full !== 1'b1; i++) @(negedge lclk);
        chk(nm, full, 1);
    endtask
    task automatic tog(output int a, b);
        logic p1, p2;
        a = 0;
        b = 0;
        @(negedge lclk);
        p1 = dclk1;
        p2 = dclk2;
        repeat (10) begin
            @(negedge lclk);
            a += (dclk1 !== p1);
            b += (dclk2 !== p2);
            p1 = dclk1;
            p2 = dclk2;
        end
        @(posedge mclk);
    endtask
    task automatic sw_wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1;
        @(posedge mclk);
        wr <= 0;
    endtask
    task automatic sw_rd(input logic [1:0] a, output logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1;
        @(posedge mclk);
        rd <= 0;
        #1 v = rdata;
    endtask
    // Polling starts late so the busy flag of the new frame is already up
    task automatic fwait();
        logic [15:0] s;
        repeat (4) @(posedge mclk);
        s = 16'h0001;
        for (int i = 0; i < 300 && s[0] !== 1'b0; i++) sw_rd(C_STAT, s);
        chk("frame busy", s & 16'h0001, 0);
    endtask
    task automatic dev_wr(input logic [3:0] a, input logic [15:0] v);
        sw_wr(C_DATA, v);
        sw_wr(C_CMD, {12'h000, a});
        fwait();
        if (REG_MAPPED[a]) m[a] = v;
    endtask
    task automatic dev_rd(input logic [3:0] a, output logic [15:0] v);
        sw_wr(C_CMD, {11'h000, 1'b1, a});
        fwait();
        sw_rd(C_DATA, v);
    endtask
    task automatic rd_all();
        for (int a = 0; a < 16; a++) begin
            dev_rd(4'(a), d);
            chk("register", d, m[a]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    // Link clock offset so its edges never meet the controller's
    initial begin
        lclk = 0;
        #1.3;
        forever #3 lclk = ~lclk;
    end
    initial begin
        #250000;
        n_mismatch++;
        test_done();
    end
    initial begin
        void'($urandom(91435));
        arst_n = 0;
        supply_ok = 0;
        addr = 0;
        wdata = 0;
        wr = 0;
        rd = 0;
        n_mismatch = 0;
        check_count = 0;
        foreach (m[i]) m[i] = REG_RST[i] & {16{REG_MAPPED[i]}};
        repeat (2) @(posedge mclk);
        arst_n <= 1;
        for (n = 0; n < 200 && busy !== 1'b1; n++) @(negedge lclk);
        chk("early valid", valid, 0);
        chk("poc wait", 16'(n >= POC_N), 1);
        for (n = 0; n < 200 && busy === 1'b1; n++) @(negedge lclk);
        chk("cal length", 16'(n), 16'(CAL_N));
        lwait(3);
        chk("valid", valid, 1);
        chk("full", full, 1);
        // Pin writes before supply must not reach the converter
        sw_wr(C_PINS, 16'h0004);
        lwait(4);
        chk("pin early", lnk_if.pd_first, 0);
        supply_ok <= 1;
        lwait(10);
        tog(n1, n2);
        chk("dclk1 down", 16'(n1), 0);
        chk("dclk2 run", 16'(n2), 10);
        sw_wr(C_PINS, 16'h0000);
        rd_all();
        dev_wr(A_MAIN_CFG, 16'h2800);
        lwait(8);
        tog(n1, n2);
        chk("pin mode", 16'(n1), 10);
        sw_wr(C_PINS, 16'h0001);
        lwait(8);
        tog(n1, n2);
        chk("ecm mode", 16'(n1), 0);
        chk("full drop", full, 0);
        for (int a = 0; a < 16; a++) begin
            d = 16'($urandom);
            if (a == 0) d = d & 16'h33FF;
            dev_wr(4'(a), d);
        end
        rd_all();
        sw_wr(C_PINS, 16'h0003);
        wait_hi("pin cal");
        sw_wr(C_PINS, 16'h0001);
        dev_wr(A_CM_ADJ, m[1] ^ 16'h0020);
        chk("full change", full, 0);
        dev_wr(A_MAIN_CFG, m[0] | CAL_MASK);
        wait_hi("reg cal");
        sw_wr(C_PINS, 16'h0061);
        lwait(8);
        tog(n1, n2);
        chk("rst dclk1", 16'(n1), 0);
        chk("rst dclk2", 16'(n2), 0);
        sw_wr(C_PINS, 16'h0009);
        lwait(8);
        tog(n1, n2);
        chk("sep dclk1", 16'(n1), 10);
        chk("sep dclk2", 16'(n2), 0);
        test_done();
    end
endmodule
